// File: design/flash_ctl.v
/*
 * Flash memory controller: wait-state reads with a one-line (128-bit) prefetch
 * buffer, page/mass erase, half-word programming, option bytes with
 * read and write protection, two-key unlock of control and options.
 * Assumes one clock REF_CLK, a synchronous system reset SRST and a
 * power-on indication POR_RST in the same domain, and a register
 * master that never issues read and write strobes together.
 */
`timescale 1ns/1ps
`include "flash_ctl_map.vh"

// How it works
// [RULE1] Software picks wait cycles; reads honour them
// [RULE2] Prefetch on after reset, two 64-bit lines; code keeps one 128-bit line
// [RULE3] Prefetch toggled only at safe clock settings
// [RULE4] Half-cycle bit changed only at safe clocks
// [RULE5] Erase writes every half-word to 0xFFFF
// [RULE6] Programming non-erased location sets program error
// [RULE7] Page erase touches only selected page
// [RULE8] Erase/program done sets flag, optional interrupt
// [RULE9] Software erases only valid unprotected pages
// [RULE10] Mass erase clears whole main array; code skips guarded four-page groups unless forced by RULE15
// [RULE11] Programming takes one half-word per access
// [RULE12] Protected pages unchanged; program sets protect error
// [RULE13] Protection granule is four pages
// [RULE14] Read guard byte not 0xA5 blocks reads
// [RULE15] Releasing read guard forces mass erase
// [RULE16] Read guard reloads only at power-on
// [RULE17] Control locked at reset; two keys unlock
// [RULE18] Bad key locks everything until reset
// [RULE19] Lock bit relocks at once
// [RULE20] Option erase/program done sets flag, interrupt
// [RULE21] Option writes need option key sequence
// [RULE22] Options locked after reset; effect after reset
// [RULE23] Reload options; bad complement forces 0xFF
// [RULE24] Guard bit zero protects four-page group
// [RULE25] Busy while erasing; new requests ignored
module flash_ctl #(
    parameter ADDR_W = 16,
    parameter PAGE_BITS = 9
) (
    input wire REF_CLK,
    input wire SRST,
    input wire POR_RST,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    input wire RD_REQ,
    input wire [ADDR_W-1:0] RD_ADDR,
    output wire RD_READY,
    output reg RD_VALID,
    output reg [15:0] RD_DATA,
    output reg RD_ERR,
    output wire BUSY,
    output wire OP_DONE_IRQ
);

localparam WORDS = 1 << ADDR_W;
localparam TAG_W = ADDR_W - 3;
localparam S_IDLE = 2'b01;
localparam S_ERASE = 2'b10;

// ****************************************
// Storage
// ****************************************
reg [15:0] mem [0:WORDS-1];
reg [127:0] ob_ff;
initial ob_ff = `OB_FACTORY;

// ****************************************
// State
// ****************************************
reg [1:0] lat_ff, state_ff;
reg half_ff, pf_en_ff, unlocked_ff, key_stage_ff, hard_lock_ff, ob_stage_ff;
reg optbyte_write_en_ff, force_ff, read_guard_ff, optbyte_error_flag_ff;
reg pg_ff, per_ff, mer_ff, obpg_ff, ober_ff, irq_en_ff;
reg [ADDR_W-1:0] addr_ff, cur_ff, end_ff;
reg op_done_flag_ff, program_err_flag_ff, wprot_err_flag_ff;
reg [31:0] page_guard_bytes_ff;

// Option-byte check: bad complement gives 0xFF and error
function [8:0] ob_check;
    input [7:0] val;
    input [7:0] cpl;
    begin
        ob_check = ((val == ~cpl) || (val == `OB_BLANK && cpl == `OB_BLANK)) ?
                   {1'b0, val} : {1'b1, `OB_BLANK};
    end
endfunction

// Page guard lookup, one bit per four pages
function guarded;
    input [ADDR_W-1:0] a;
    input [31:0] wrp;
    reg [ADDR_W-1:0] grp;
    begin
        grp = a >> (PAGE_BITS + 2); // RULE13
        guarded = ~wrp[grp[4:0]]; // RULE24
    end
endfunction

wire [7:0] ob_val [0:7];
wire [7:0] ob_bad;
genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_ob
        wire [8:0] chk = ob_check(ob_ff[16*gi +: 8], ob_ff[16*gi+8 +: 8]);
        assign ob_val[gi] = chk[7:0];
        assign ob_bad[gi] = chk[8];
    end
endgenerate

// ****************************************
// Register access decode
// ****************************************
wire busy = state_ff[1];
wire open_ok = unlocked_ff && !hard_lock_ff;
wire wr_key = REG_WR && REG_ADDR == `OFS_MAIN_KEY;
wire wr_obkey = REG_WR && REG_ADDR == `OFS_OB_KEY;
wire wr_two = REG_WR && REG_ADDR == `OFS_CTL_TWO && open_ok;
wire wr_stat = REG_WR && REG_ADDR == `OFS_STATUS;
wire wr_data = REG_WR && REG_ADDR == `OFS_DATA && open_ok && !busy; // RULE25
wire start = wr_two && REG_WDATA[`TWO_START] && !busy; // RULE25
wire [15:0] cur_hw = mem[addr_ff];
wire [3:0] ob_idx = addr_ff[3:0];
// Half-word program attempt
wire hw_prog = wr_data && pg_ff; // RULE11
wire hw_prot = guarded(addr_ff, page_guard_bytes_ff);
wire hw_dirty = cur_hw != `ERASED_HW;
wire hw_ok = hw_prog && !hw_prot && !hw_dirty;
// Option-byte program and erase attempts
wire ob_prog = wr_data && obpg_ff && optbyte_write_en_ff; // RULE21
wire ob_dirty = ob_ff[8*ob_idx +: 8] != `OB_BLANK;
wire ob_ok = ob_prog && !ob_dirty;
wire ob_open = ob_ok && ob_idx == 4'h0 && REG_WDATA[7:0] == `RDP_OPEN && read_guard_ff;
wire ob_erase = start && ober_ff && optbyte_write_en_ff; // RULE21
// Erase starts
wire page_prot = guarded(addr_ff, page_guard_bytes_ff);
wire pe_go = start && per_ff && !page_prot; // RULE12
wire me_go = start && mer_ff;
wire [ADDR_W-1:0] page_base = addr_ff & ~{{(ADDR_W-PAGE_BITS){1'b0}}, {PAGE_BITS{1'b1}}};
wire cur_skip = !force_ff && guarded(cur_ff, page_guard_bytes_ff);
wire erase_last = busy && cur_ff == end_ff;
// Array write port
wire mem_we = (busy && !cur_skip) || hw_ok;
wire [ADDR_W-1:0] mem_wa = busy ? cur_ff : addr_ff;
wire [15:0] mem_wd = busy ? `ERASED_HW : REG_WDATA[15:0]; // RULE5

// ****************************************
// Option storage
// ****************************************
always @(posedge REF_CLK) begin
    if (ob_erase) begin
        ob_ff <= {16{`OB_BLANK}};
    end else if (ob_ok) begin
        ob_ff[8*ob_idx +: 8] <= REG_WDATA[7:0];
        ob_ff[8*(ob_idx ^ 4'h1) +: 8] <= ~REG_WDATA[7:0];
    end
end

always @(posedge REF_CLK) begin
    if (mem_we) begin
        mem[mem_wa] <= mem_wd;
    end
end

// ****************************************
// Control, keys, flags and sequencer
// ****************************************
always @(posedge REF_CLK) begin
    if (SRST) begin
        lat_ff <= `RST_LAT;
        pf_en_ff <= `RST_PF_EN; // RULE2
        unlocked_ff <= 1'b0; // RULE17
        optbyte_write_en_ff <= 1'b0; // RULE22
        {half_ff, key_stage_ff, hard_lock_ff, ob_stage_ff, force_ff} <= 5'h00;
        {pg_ff, per_ff, mer_ff, obpg_ff, ober_ff, irq_en_ff} <= 6'h00;
        {op_done_flag_ff, program_err_flag_ff, wprot_err_flag_ff} <= 3'h0;
        addr_ff <= {ADDR_W{1'b0}};
        cur_ff <= {ADDR_W{1'b0}};
        end_ff <= {ADDR_W{1'b0}};
        state_ff <= S_IDLE;
        // Reload guard bytes and option error on every reset; read guard at power-on only
        page_guard_bytes_ff <= {ob_val[7], ob_val[6], ob_val[5], ob_val[4]}; // RULE23
        optbyte_error_flag_ff <= |ob_bad; // RULE23
        if (POR_RST) begin
            read_guard_ff <= ob_val[0] != `RDP_OPEN; // RULE14 RULE16
        end
    end else begin
        if (REG_WR && REG_ADDR == `OFS_CTL_ONE) begin
            lat_ff <= REG_WDATA[`ONE_LAT +: 2]; // RULE1
            half_ff <= REG_WDATA[`ONE_HALF];
            pf_en_ff <= REG_WDATA[`ONE_PF_EN];
        end
        if (REG_WR && REG_ADDR == `OFS_ADDR) begin
            addr_ff <= REG_WDATA[ADDR_W-1:0];
        end
        // Main key: wrong value or order locks until reset
        if (wr_key && !hard_lock_ff) begin
            if (unlocked_ff) begin
                hard_lock_ff <= 1'b1; // RULE18
            end else if (!key_stage_ff && REG_WDATA == `FIRST_UNLOCK_KEY) begin
                key_stage_ff <= 1'b1;
            end else if (key_stage_ff && REG_WDATA == `SECOND_UNLOCK_KEY) begin
                unlocked_ff <= 1'b1; // RULE17
                key_stage_ff <= 1'b0;
            end else begin
                hard_lock_ff <= 1'b1; // RULE18
            end
        end
        // Option key: same pair, needs main unlock first
        if (wr_obkey && open_ok) begin
            if (!ob_stage_ff && REG_WDATA == `FIRST_UNLOCK_KEY) begin
                ob_stage_ff <= 1'b1;
            end else if (ob_stage_ff && REG_WDATA == `SECOND_UNLOCK_KEY) begin
                optbyte_write_en_ff <= 1'b1; // RULE21
                ob_stage_ff <= 1'b0;
            end else begin
                hard_lock_ff <= 1'b1; // RULE18
            end
        end
        if (wr_two) begin
            pg_ff <= REG_WDATA[`TWO_PG];
            per_ff <= REG_WDATA[`TWO_PER];
            mer_ff <= REG_WDATA[`TWO_MER];
            obpg_ff <= REG_WDATA[`TWO_OBPG];
            ober_ff <= REG_WDATA[`TWO_OBER];
            irq_en_ff <= REG_WDATA[`TWO_IRQ_EN];
            if (!REG_WDATA[`TWO_OPTBYTE_WRITE_EN]) begin
                optbyte_write_en_ff <= 1'b0; // RULE21
            end
            if (REG_WDATA[`TWO_LOCK]) begin
                unlocked_ff <= 1'b0; // RULE19
                optbyte_write_en_ff <= 1'b0;
            end
        end
        // Sequencer
        case (state_ff)
            S_IDLE: begin
                if (pe_go) begin
                    cur_ff <= page_base; // RULE7
                    end_ff <= page_base | {{(ADDR_W-PAGE_BITS){1'b0}}, {PAGE_BITS{1'b1}}};
                    force_ff <= 1'b0;
                    state_ff <= S_ERASE;
                end else if (me_go || ob_open) begin
                    cur_ff <= {ADDR_W{1'b0}}; // RULE10
                    end_ff <= {ADDR_W{1'b1}};
                    force_ff <= ob_open; // RULE15
                    state_ff <= S_ERASE;
                end
            end
            S_ERASE: begin
                cur_ff <= cur_ff + 1'b1;
                if (erase_last) begin
                    state_ff <= S_IDLE;
                end
            end
            default: begin
                state_ff <= S_IDLE;
            end
        endcase
        // Flags: hardware set wins over write-one clear
        if (erase_last || hw_ok || ob_ok || ob_erase) begin
            op_done_flag_ff <= 1'b1; // RULE8 RULE20
        end else if (wr_stat && REG_WDATA[`ST_DONE]) begin
            op_done_flag_ff <= 1'b0;
        end
        if ((hw_prog && !hw_prot && hw_dirty) || (ob_prog && ob_dirty)) begin
            program_err_flag_ff <= 1'b1; // RULE6
        end else if (wr_stat && REG_WDATA[`ST_PERR]) begin
            program_err_flag_ff <= 1'b0;
        end
        if ((hw_prog && hw_prot) || (start && per_ff && page_prot)) begin
            wprot_err_flag_ff <= 1'b1; // RULE12
        end else if (wr_stat && REG_WDATA[`ST_WPERR]) begin
            wprot_err_flag_ff <= 1'b0;
        end
    end
end

// ****************************************
// Array reads with wait states and prefetch
// ****************************************
reg rd_busy_ff, buf_ok_ff;
reg [1:0] rd_cnt_ff;
reg [ADDR_W-1:0] rd_addr_ff;
reg [127:0] buf_ff;
reg [TAG_W-1:0] tag_ff;
wire [127:0] line_w;
wire [TAG_W-1:0] req_tag = RD_ADDR[ADDR_W-1:3];
wire pf_hit = pf_en_ff && buf_ok_ff && tag_ff == req_tag;
wire take = RD_REQ && !rd_busy_ff;
wire fill = rd_busy_ff && rd_cnt_ff == 2'h0;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_line
        assign line_w[16*gi +: 16] = mem[{rd_addr_ff[ADDR_W-1:3], gi[2:0]}];
    end
endgenerate

always @(posedge REF_CLK) begin
    if (SRST) begin
        {rd_busy_ff, buf_ok_ff, RD_VALID, RD_ERR} <= 4'h0;
        rd_cnt_ff <= 2'h0;
        rd_addr_ff <= {ADDR_W{1'b0}};
        buf_ff <= 128'h0;
        tag_ff <= {TAG_W{1'b0}};
        RD_DATA <= 16'h0000;
    end else begin
        RD_VALID <= 1'b0;
        RD_ERR <= 1'b0;
        if (take && read_guard_ff) begin
            RD_VALID <= 1'b1; // RULE14
            RD_ERR <= 1'b1;
            RD_DATA <= 16'h0000;
        end else if (take && pf_hit) begin
            RD_VALID <= 1'b1;
            RD_DATA <= buf_ff[16*RD_ADDR[2:0] +: 16];
        end else if (take) begin
            rd_busy_ff <= 1'b1;
            rd_cnt_ff <= lat_ff; // RULE1
            rd_addr_ff <= RD_ADDR;
        end else if (fill) begin
            rd_busy_ff <= 1'b0;
            RD_VALID <= 1'b1;
            RD_DATA <= mem[rd_addr_ff];
            buf_ff <= line_w; // RULE2
            tag_ff <= rd_addr_ff[ADDR_W-1:3];
            buf_ok_ff <= 1'b1;
        end else if (rd_busy_ff) begin
            rd_cnt_ff <= rd_cnt_ff - 2'h1;
        end
        if (mem_we) begin
            buf_ok_ff <= 1'b0;
        end
    end
end

// ****************************************
// Register read port
// ****************************************
always @(posedge REF_CLK) begin
    if (SRST) begin
        REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
        case (REG_ADDR)
            `OFS_CTL_ONE: REG_RDATA <= {26'h0, pf_en_ff, pf_en_ff, half_ff, 1'b0, lat_ff};
            `OFS_STATUS: REG_RDATA <= {26'h0, op_done_flag_ff, wprot_err_flag_ff, 1'b0,
                                       program_err_flag_ff, 1'b0, busy};
            `OFS_CTL_TWO: REG_RDATA <= {19'h0, irq_en_ff, 2'h0, optbyte_write_en_ff, 1'b0,
                                        !unlocked_ff, 1'b0, ober_ff, obpg_ff, 1'b0,
                                        mer_ff, per_ff, pg_ff};
            `OFS_ADDR: REG_RDATA <= {{(32-ADDR_W){1'b0}}, addr_ff};
            `OFS_OBCS: REG_RDATA <= {30'h0, read_guard_ff, optbyte_error_flag_ff};
            `OFS_WRP: REG_RDATA <= page_guard_bytes_ff;
            default: REG_RDATA <= 32'h0;
        endcase
    end else begin
        REG_RDATA <= 32'h0;
    end
end

assign RD_READY = !rd_busy_ff;
assign BUSY = busy; // RULE25
assign OP_DONE_IRQ = op_done_flag_ff && irq_en_ff; // RULE8

endmodule // flash_ctl

// File: design/flash_ctl_map.vh
/*
 * Register offsets, field positions, reset values and key words of the
 * flash controller. Definitions only; included by flash_ctl.v.
 */
`ifndef FLASH_CTL_MAP_VH
`define FLASH_CTL_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_CTL_ONE 8'h00
`define OFS_MAIN_KEY 8'h04
`define OFS_OB_KEY 8'h08
`define OFS_STATUS 8'h0C
`define OFS_CTL_TWO 8'h10
`define OFS_ADDR 8'h14
`define OFS_DATA 8'h18
`define OFS_OBCS 8'h1C
`define OFS_WRP 8'h20

// ****************************************
// Field positions
// ****************************************
`define ONE_LAT 0
`define ONE_HALF 3
`define ONE_PF_EN 4
`define ONE_PF_ON 5
`define ST_BUSY 0
`define ST_PERR 2
`define ST_WPERR 4
`define ST_DONE 5
`define TWO_PG 0
`define TWO_PER 1
`define TWO_MER 2
`define TWO_OBPG 4
`define TWO_OBER 5
`define TWO_START 6
`define TWO_LOCK 7
`define TWO_OPTBYTE_WRITE_EN 9
`define TWO_IRQ_EN 12
`define OBCS_ERR 0
`define OBCS_RDP 1

// ****************************************
// Values
// ****************************************
`define FIRST_UNLOCK_KEY 32'h45670123
`define SECOND_UNLOCK_KEY 32'hCDEF89AB
`define ERASED_HW 16'hFFFF
`define OB_BLANK 8'hFF
`define RDP_OPEN 8'hA5
`define RST_LAT 2'h0
`define RST_PF_EN 1'b1
`define OB_FACTORY 128'h00FF00FF00FF00FF00FF00FF00FF5AA5

`endif

// File: tb/flash_ctl_asserts.sv
/*
 * Port checker for flash_ctl: erase runs, completion interrupt, array read timing.
 * Assumes it is bound onto flash_ctl, one clock REF_CLK, synchronous SRST.
 */
`timescale 1ns/1ps
`include "flash_ctl_map.vh"
module flash_ctl_asserts #(
    parameter ADDR_W = 16,
    parameter PAGE_BITS = 9
) (
    input wire REF_CLK,
    input wire SRST,
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire RD_REQ,
    input wire RD_READY,
    input wire RD_VALID,
    input wire [15:0] RD_DATA,
    input wire RD_ERR,
    input wire BUSY,
    input wire OP_DONE_IRQ
);
    localparam int PAGE_HW = 1 << PAGE_BITS;
    localparam int ARR_HW = 1 << ADDR_W;
    logic [ADDR_W:0] busy_cnt_ff;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    // ****************************************
    // Length of the current busy run
    // ****************************************
    always @(posedge REF_CLK) begin
        if (SRST || !BUSY) begin
            busy_cnt_ff <= '0;
        end else begin
            busy_cnt_ff <= busy_cnt_ff + 1'b1;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    chk_busy_cause: assert property ($rose(BUSY) |-> $past(REG_WR) &&
        ($past(REG_ADDR) == `OFS_CTL_TWO || $past(REG_ADDR) == `OFS_DATA))
        else $error("busy rose without a control or data write");
    chk_erase_span: assert property ($fell(BUSY) && busy_cnt_ff > 2 |->
        busy_cnt_ff >= PAGE_HW && busy_cnt_ff <= ARR_HW + 2)
        else $error("erase run length out of range");
    chk_irq_rise: assert property ($rose(OP_DONE_IRQ) |-> $past(REG_WR) ||
        $past(REG_WR, 2) || $past(BUSY) || $past(BUSY, 2))
        else $error("completion interrupt without an operation");
    chk_irq_fall: assert property ($fell(OP_DONE_IRQ) |-> $past(REG_WR))
        else $error("completion interrupt dropped without a write");
    chk_rd_latency: assert property (RD_REQ && RD_READY |-> ##[1:5] RD_VALID)
        else $error("array read answer too late");
    chk_rd_err_data: assert property (RD_ERR |-> RD_VALID && RD_DATA == 16'h0000)
        else $error("blocked read shows data");
    chk_rd_ready_back: assert property (!RD_READY |-> ##[1:5] RD_READY)
        else $error("read path stuck");
    chk_valid_cause: assert property (RD_VALID |-> $past(RD_REQ) || !$past(RD_READY))
        else $error("read answer without request");

    cover property ($fell(BUSY) && busy_cnt_ff > 2);
    cover property ($rose(OP_DONE_IRQ));
    cover property (RD_ERR);
endmodule // flash_ctl_asserts

// File: tb/flash_ctl_tb_top.sv
/*
 * Self-checking bench for flash_ctl with a small array (64-half-word pages).
 * Assumes host_bus_model drives the bus and flash_ctl_asserts is bound.
 */
`timescale 1ns/1ps
`include "flash_ctl_map.vh"
module flash_ctl_tb_top;
    logic ref_clk, srst, por_rst, reg_wr, reg_rd, rd_req, rd_ready, rd_valid, rd_err;
    logic busy, irq, e;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [11:0] rd_addr;
    logic [15:0] rd_data, d;
    int errors = 0;
    int n_compared = 0;
    int n;

    flash_ctl #(.ADDR_W(12), .PAGE_BITS(6)) flash_ctl_inst (.REF_CLK(ref_clk), .SRST(srst),
        .POR_RST(por_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .RD_REQ(rd_req), .RD_ADDR(rd_addr),
        .RD_READY(rd_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data), .RD_ERR(rd_err),
        .BUSY(busy), .OP_DONE_IRQ(irq));
    host_bus_model #(.ADDR_W(12)) host_bus_model_inst (.clk(ref_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_err(rd_err));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        host_bus_model_inst.wr(a, w);
    endtask
    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        logic [31:0] r;
        host_bus_model_inst.rd(a, r);
        chk(name, exp, r & m);
    endtask
    task automatic ardc(input logic [11:0] a, input logic [15:0] exp);
        host_bus_model_inst.ard(a, d, e, n);
        chk("array data", {16'h0, exp}, {16'h0, d});
        chk("array error", 32'h0, {31'h0, e});
    endtask
    task automatic prog(input logic [11:0] a, input logic [15:0] w);
        wr(`OFS_ADDR, {20'h0, a});
        wr(`OFS_DATA, {16'h0, w});
    endtask
    task automatic wait_idle();
        int c;
        c = 0;
        while (busy !== 1'b0 && c < 9000) begin
            @(posedge ref_clk);
            c++;
        end
        chk("busy end", 32'h0, {31'h0, busy});
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rst(input logic por);
        srst <= 1'b1;
        por_rst <= por;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        por_rst <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        srst = 1'b1;
        por_rst = 1'b1;
        rst(1'b1);
        rdc("ctl one", `OFS_CTL_ONE, 32'h1B, 32'h10);
        rdc("lock bit", `OFS_CTL_TWO, 32'h80, 32'h80);
        wr(`OFS_CTL_TWO, 32'h04);
        wr(`OFS_CTL_TWO, 32'h44);
        rdc("locked idle", `OFS_STATUS, 32'h1, 32'h0);
        host_bus_model_inst.unlock_main();
        wr(`OFS_CTL_TWO, 32'h1004);
        wr(`OFS_CTL_TWO, 32'h1044);
        rdc("busy flag", `OFS_STATUS, 32'h1, 32'h1);
        wait_idle();
        rdc("erase done", `OFS_STATUS, 32'h35, 32'h20);
        chk("irq", 32'h1, {31'h0, irq});
        ardc(12'h000, 16'hFFFF);
        ardc(12'hFFF, 16'hFFFF);
        wr(`OFS_STATUS, 32'h34);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test mass erase finished");
        for (int lat = 0; lat < 4; lat++) begin
            wr(`OFS_CTL_ONE, 32'h10 | 32'(lat));
            host_bus_model_inst.ard(12'h400 + 12'(lat * 32), d, e, n);
            chk("miss cycles", 32'(lat + 2), n);
            host_bus_model_inst.ard(12'h407 + 12'(lat * 32), d, e, n);
            chk("hit cycles", 32'h1, n);
        end
        wr(`OFS_CTL_ONE, 32'h10);
        $display("test read timing finished");
        wr(`OFS_CTL_TWO, 32'h1001);
        prog(12'h040, 16'h1234);
        prog(12'h005, 16'hA5A5);
        prog(12'h080, 16'h5A5A);
        prog(12'h040, 16'h0000);
        rdc("program error", `OFS_STATUS, 32'h34, 32'h24);
        ardc(12'h040, 16'h1234);
        wr(`OFS_STATUS, 32'h34);
        wr(`OFS_ADDR, 32'h40);
        wr(`OFS_CTL_TWO, 32'h1002);
        wr(`OFS_CTL_TWO, 32'h1042);
        wait_idle();
        rdc("page done", `OFS_STATUS, 32'h35, 32'h20);
        ardc(12'h040, 16'hFFFF);
        ardc(12'h005, 16'hA5A5);
        ardc(12'h080, 16'h5A5A);
        $display("test program and page erase finished");
        wr(`OFS_STATUS, 32'h34);
        wr(`OFS_CTL_TWO, 32'h1081);
        prog(12'h100, 16'h1111);
        ardc(12'h100, 16'hFFFF);
        host_bus_model_inst.unlock_main();
        host_bus_model_inst.unlock_opt();
        wr(`OFS_CTL_TWO, 32'h1210);
        wr(`OFS_ADDR, 32'h8);
        wr(`OFS_DATA, 32'hFE);
        rdc("option done", `OFS_STATUS, 32'h20, 32'h20);
        rdc("guard before reset", `OFS_WRP, 32'hFFFFFFFF, 32'hFFFFFFFF);
        rst(1'b0);
        rdc("guard after reset", `OFS_WRP, 32'hFFFFFFFF, 32'hFFFFFFFE);
        host_bus_model_inst.unlock_main();
        wr(`OFS_CTL_TWO, 32'h1001);
        prog(12'h0C0, 16'h0000);
        rdc("protect error", `OFS_STATUS, 32'h14, 32'h10);
        ardc(12'h0C0, 16'hFFFF);
        prog(12'h100, 16'h4321);
        ardc(12'h100, 16'h4321);
        $display("test protection finished");
        rst(1'b0);
        wr(`OFS_MAIN_KEY, `SECOND_UNLOCK_KEY);
        host_bus_model_inst.unlock_main();
        wr(`OFS_CTL_TWO, 32'h04);
        wr(`OFS_CTL_TWO, 32'h44);
        rdc("hard lock", `OFS_STATUS, 32'h1, 32'h0);
        rst(1'b0);
        host_bus_model_inst.unlock_main();
        host_bus_model_inst.unlock_opt();
        wr(`OFS_CTL_TWO, 32'h0220);
        wr(`OFS_CTL_TWO, 32'h0260);
        rdc("erase option done", `OFS_STATUS, 32'h20, 32'h20);
        rst(1'b0);
        ardc(12'h100, 16'h4321);
        rst(1'b1);
        host_bus_model_inst.ard(12'h100, d, e, n);
        chk("read blocked", 32'h1, {31'h0, e});
        rdc("option error", `OFS_OBCS, 32'h1, 32'h0);
        host_bus_model_inst.unlock_main();
        host_bus_model_inst.unlock_opt();
        wr(`OFS_CTL_TWO, 32'h0210);
        prog(12'h000, 16'h00A5);
        wait_idle();
        rst(1'b1);
        ardc(12'h100, 16'hFFFF);
        $display("test keys and read guard finished");
        end_of_test();
    end
endmodule // flash_ctl_tb_top

bind flash_ctl flash_ctl_asserts #(.ADDR_W(ADDR_W), .PAGE_BITS(PAGE_BITS))
    flash_ctl_asserts_inst (.REF_CLK(REF_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .RD_REQ(RD_REQ), .RD_READY(RD_READY), .RD_VALID(RD_VALID),
    .RD_DATA(RD_DATA), .RD_ERR(RD_ERR), .BUSY(BUSY), .OP_DONE_IRQ(OP_DONE_IRQ));

// File: tb/host_bus_model.sv
/*
 * Software side of flash_ctl: register bus and array read tasks.
 * Assumes every task is entered just after a rising edge of clk.
 */
`timescale 1ns/1ps
`include "flash_ctl_map.vh"
module host_bus_model #(
    parameter ADDR_W = 12
) (
    input wire clk,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire [31:0] reg_rdata,
    output logic rd_req,
    output logic [ADDR_W-1:0] rd_addr,
    input wire rd_valid,
    input wire [15:0] rd_data,
    input wire rd_err
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd_req = 1'b0;
        rd_addr = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask

    task automatic unlock_main();
        wr(`OFS_MAIN_KEY, `FIRST_UNLOCK_KEY);
        wr(`OFS_MAIN_KEY, `SECOND_UNLOCK_KEY);
    endtask

    task automatic unlock_opt();
        wr(`OFS_OB_KEY, `FIRST_UNLOCK_KEY);
        wr(`OFS_OB_KEY, `SECOND_UNLOCK_KEY);
    endtask

    // Cycles counted from the taking edge to the answer
    task automatic ard(input logic [ADDR_W-1:0] a, output logic [15:0] d, output logic e,
                       output int n);
        rd_addr <= a;
        rd_req <= 1'b1;
        n = 0;
        @(posedge clk);
        rd_req <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (rd_valid !== 1'b1 && n < 20);
        d = rd_data;
        e = rd_err;
    endtask
endmodule // host_bus_model
